/* File: shared/irl_flag_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface irl_flag_if;
  logic [7:0] hw_set;
  logic [7:0] ack_clr;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] flags;
  modport ctrl (output hw_set, output ack_clr, output wr_en, output wr_data, input flags);
  modport bank (input hw_set, input ack_clr, input wr_en, input wr_data, output flags);
endinterface : irl_flag_if
`default_nettype wire

/* File: shared/irl_pkg.sv */
package irl_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_GROUP0 = 12'hfc0;
  localparam logic [11:0] OFS_GROUP1 = 12'hfc3;
  localparam logic [11:0] OFS_GROUP2 = 12'hfc6;
  localparam logic [11:0] OFS_EDGE_SEL = 12'hfc7;
  localparam logic [11:0] OFS_GLOBAL_EN = 12'hfc8;
  localparam logic [7:0] RESET_FLAGS = 8'h00;
  localparam logic [7:0] RESET_EDGE_SEL = 8'h00;
  localparam int NUM_GROUPS = 3;
  localparam int GLOBAL_EN_BIT = 7;
  // ---------------------------------------------------------------
  // Group 0 bit positions
  // ---------------------------------------------------------------
  localparam int BIT_TIMER2 = 7;
  localparam int BIT_TIMER1 = 6;
  localparam int BIT_TIMER0 = 5;
  localparam int BIT_SER0_RX = 4;
  localparam int BIT_SER0_TX = 3;
  localparam int BIT_TWO_WIRE = 2;
  localparam int BIT_SYNC_SER = 1;
  localparam int BIT_CONVERTER = 0;
  // ---------------------------------------------------------------
  // Group 2 bit positions
  // ---------------------------------------------------------------
  localparam int BIT_TIMER3 = 7;
  localparam int BIT_SER1_RX = 6;
  localparam int BIT_SER1_TX = 5;
  localparam int BIT_DMA = 4;
  localparam int BIT_PORT_C_HI = 3;
  typedef logic [7:0] irl_byte_t;
endpackage : irl_pkg

/* File: test/irl_request_latches_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module irl_request_latches_chk
  import irl_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [irl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic timer2_req,
  input wire logic converter_req,
  input wire logic dma_req,
  input wire logic [7:0] port_a_edge_req,
  input wire logic [7:0] port_d_edge_req,
  input wire logic [7:0] ack_group0,
  input wire logic core_irq,
  input wire logic [7:0] pending_group0,
  input wire logic [7:0] pending_group1,
  input wire logic [7:0] pending_group2
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_t2_set; timer2_req |-> ##2 pending_group0[7]; endproperty
  a_t2_set: assert property (p_t2_set) else $error("timer2 flag missing");
  property p_dma_set; dma_req |-> ##2 pending_group2[4]; endproperty
  a_dma_set: assert property (p_dma_set) else $error("dma flag missing");
  property p_ack; ack_group0[0] && !converter_req && !(reg_wr && reg_addr == OFS_GROUP0)
    |-> ##2 !pending_group0[0]; endproperty
  a_ack: assert property (p_ack) else $error("ack left flag set");
  property p_wr; reg_wr && reg_addr == OFS_GROUP1 && port_a_edge_req == 8'h00
    && port_d_edge_req == 8'h00 |-> ##2 pending_group1 == $past(reg_wdata, 2); endproperty
  a_wr: assert property (p_wr) else $error("written flags wrong");
  property p_keep; converter_req && reg_wr && reg_addr == OFS_GROUP0 && !reg_wdata[0]
    |-> ##2 pending_group0[0]; endproperty
  a_keep: assert property (p_keep) else $error("request lost");
  property p_irq; core_irq |-> (pending_group0 | pending_group1 | pending_group2) != 8'h00;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without flag");
  property p_rise; $rose(pending_group2[4]) |-> $past(dma_req, 2) || $past(reg_wr, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("flag set without cause");
  property p_rd; reg_rd && reg_addr == OFS_GROUP0 |=> reg_rdata == pending_group0; endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");
endmodule : irl_request_latches_chk
bind irl_request_latches irl_request_latches_chk u_chk (.clk, .rstn, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .timer2_req, .converter_req, .dma_req, .port_a_edge_req,
  .port_d_edge_req, .ack_group0, .core_irq, .pending_group0, .pending_group1, .pending_group2);
`default_nettype wire

/* File: test/irl_request_latches_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module irl_request_latches_tb;
  import irl_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [23:0] ack = 24'h0;
  logic [7:0] reg_rdata;
  logic core_irq;
  logic [7:0] pend0, pend1, pend2;
  logic [31:0] src;
  int err_total = 0;
  int n_tests = 0;
  always #20 clk = ~clk;
  irl_src_model u_src (.clk(clk), .src(src));
  irl_request_latches u_irl_request_latches (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer2_req(src[31]), .timer1_req(src[30]), .timer0_req(src[29]),
    .serial0_receive_req(src[28]), .serial0_transmit_req(src[27]), .two_wire_req(src[26]),
    .sync_serial_req(src[25]), .converter_req(src[24]), .port_a_edge_req(src[23:16]),
    .port_d_edge_req(src[15:8]), .timer3_req(src[7]), .serial1_receive_req(src[6]),
    .serial1_transmit_req(src[5]), .dma_req(src[4]), .port_c_edge_req(src[3:0]),
    .ack_group0(ack[23:16]), .ack_group1(ack[15:8]), .ack_group2(ack[7:0]),
    .core_irq(core_irq), .pending_group0(pend0), .pending_group1(pend1),
    .pending_group2(pend2));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  initial begin
    int b;
    logic [11:0] a;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(OFS_GROUP0, 8'h00);
    rd(OFS_GROUP1, 8'h00);
    rd(OFS_GROUP2, 8'h00);
    wr(12'h000, 8'hff);
    rd(12'h000, 8'h00);
    $display("reset test done");
    for (b = 31; b >= 0; b--) begin
      a = b > 23 ? OFS_GROUP0 : b > 7 ? OFS_GROUP1 : OFS_GROUP2;
      if (b == 15) wr(OFS_EDGE_SEL, 8'hff);
      u_src.pulse(32'h1 << b);
      rd(a, 8'h01 << (b % 8));
      chk(b > 23 ? pend0 : b > 7 ? pend1 : pend2, 8'h01 << (b % 8));
      chk({7'h00, core_irq}, 8'h00);
      wr(a, 8'h00);
      rd(a, 8'h00);
    end
    u_src.pulse(32'h0001_0000);
    rd(OFS_GROUP1, 8'h00);
    $display("source test done");
    wr(OFS_GLOBAL_EN, 8'h80);
    rd(OFS_EDGE_SEL, 8'hff);
    rd(OFS_GLOBAL_EN, 8'h80);
    wr(OFS_GROUP2, 8'h10);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, core_irq}, 8'h01);
    @(posedge clk);
    ack <= 24'h00_0010;
    @(posedge clk);
    ack <= 24'h0;
    rd(OFS_GROUP2, 8'h00);
    chk({7'h00, core_irq}, 8'h00);
    fork
      u_src.pulse(32'h0100_0000);
      wr(OFS_GROUP0, 8'h00);
    join
    rd(OFS_GROUP0, 8'h01);
    chk({7'h00, core_irq}, 8'h01);
    @(posedge clk);
    ack <= 24'h01_0000;
    @(posedge clk);
    ack <= 24'h0;
    rd(OFS_GROUP0, 8'h00);
    chk(pend0, 8'h00);
    $display("core test done");
    summarize();
  end
endmodule : irl_request_latches_tb
`default_nettype wire

/* File: test/irl_src_model.sv */
`timescale 1ns/100ps
`default_nettype none
module irl_src_model (
  // Clock
  input wire logic clk,
  // Request pulses
  output logic [31:0] src
);
  initial src = 32'h0;
  task automatic pulse(input logic [31:0] m);
    @(posedge clk);
    src <= m;
    @(posedge clk);
    src <= 32'h0;
  endtask : pulse
endmodule : irl_src_model
`default_nettype wire

/* File: verilog/irl_flag_bank.sv */
`timescale 1ns/100ps
`default_nettype none
module irl_flag_bank
  import irl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Flag group
  irl_flag_if.bank fb
);
  import irl_pkg::*;

  // ---------------------------------------------------------------
  // Per-bit sticky flags
  // ---------------------------------------------------------------
  irl_byte_t flag;
  assign fb.flags = flag;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          flag[i] <= 1'b0;
        end else if (fb.hw_set[i]) begin
          flag[i] <= 1'b1; // R01 R13
        end else if (fb.wr_en) begin
          flag[i] <= fb.wr_data[i]; // R11 R12
        end else if (fb.ack_clr[i]) begin
          flag[i] <= 1'b0; // R10
        end
      end
    end
  endgenerate
endmodule : irl_flag_bank
`default_nettype wire

/* File: verilog/irl_request_latches.sv */
// Notes on behaviour
// R01 - A source request sets its flag, which stays set until cleared.
// R02 - With global enable on, pending flags go to the core as interrupt.
// R03 - With global enable off, flags still latch and are readable for polling.
// R04 - Group 0 bits 7..0: timer2, timer1, timer0, ser0 rx, ser0 tx, 2-wire, sync, conv.
// R05 - A flag reads 1 while its request is pending, 0 otherwise.
// R06 - Group 1 holds eight edge flags, pin 7..0 of port A or D.
// R07 - Per pin only port A or port D feeds the flag, chosen by select.
// R08 - Group 2: timer3, ser1 rx, ser1 tx, DMA, port C pins 3..0.
// R09 - Sources pulse each new request for exactly one clock.
// R10 - Core acknowledge clears that source's flag until its next request.
// R11 - Software writing 0 to a flag clears it.
// R12 - Software writing 1 sets the flag; acknowledge clears it again.
// R13 - A request in the same cycle as a clearing write keeps the flag set.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module irl_request_latches
  import irl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [irl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Group 0 sources
  input wire logic timer2_req,
  input wire logic timer1_req,
  input wire logic timer0_req,
  input wire logic serial0_receive_req,
  input wire logic serial0_transmit_req,
  input wire logic two_wire_req,
  input wire logic sync_serial_req,
  input wire logic converter_req,
  // Edge pulses from ports
  input wire logic [7:0] port_a_edge_req,
  input wire logic [7:0] port_d_edge_req,
  // Group 2 sources
  input wire logic timer3_req,
  input wire logic serial1_receive_req,
  input wire logic serial1_transmit_req,
  input wire logic dma_req,
  input wire logic [3:0] port_c_edge_req,
  // Core side
  input wire logic [7:0] ack_group0,
  input wire logic [7:0] ack_group1,
  input wire logic [7:0] ack_group2,
  output logic core_irq,
  output logic [7:0] pending_group0,
  output logic [7:0] pending_group1,
  output logic [7:0] pending_group2
);
  import irl_pkg::*;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  irl_flag_if grp [NUM_GROUPS] ();
  irl_byte_t flags0, flags1, flags2;
  irl_byte_t edge_port_select;
  logic global_interrupt_enable;
  irl_byte_t set0, set1, set2;

  // ---------------------------------------------------------------
  // Source mapping
  // ---------------------------------------------------------------
  always_comb begin
    set0 = 8'h00;
    set0[BIT_TIMER2] = timer2_req; // R04
    set0[BIT_TIMER1] = timer1_req;
    set0[BIT_TIMER0] = timer0_req;
    set0[BIT_SER0_RX] = serial0_receive_req;
    set0[BIT_SER0_TX] = serial0_transmit_req;
    set0[BIT_TWO_WIRE] = two_wire_req;
    set0[BIT_SYNC_SER] = sync_serial_req;
    set0[BIT_CONVERTER] = converter_req;
  end

  // ---------------------------------------------------------------
  // Port edge mapping
  // ---------------------------------------------------------------
  always_comb begin
    // Select 1 picks port D, 0 picks port A
    set1 = (port_d_edge_req & edge_port_select) | (port_a_edge_req & ~edge_port_select); // R06 R07
  end

  // ---------------------------------------------------------------
  // Group 2 mapping
  // ---------------------------------------------------------------
  always_comb begin
    set2 = 8'h00;
    set2[BIT_TIMER3] = timer3_req; // R08
    set2[BIT_SER1_RX] = serial1_receive_req;
    set2[BIT_SER1_TX] = serial1_transmit_req;
    set2[BIT_DMA] = dma_req;
    set2[BIT_PORT_C_HI:0] = port_c_edge_req;
  end

  // ---------------------------------------------------------------
  // Flag banks
  // ---------------------------------------------------------------
  assign grp[0].hw_set = set0; // R01 R09
  assign grp[1].hw_set = set1;
  assign grp[2].hw_set = set2;
  assign grp[0].ack_clr = ack_group0; // R10
  assign grp[1].ack_clr = ack_group1;
  assign grp[2].ack_clr = ack_group2;

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  assign grp[0].wr_en = reg_wr && hit(reg_addr, OFS_GROUP0); // R11 R12
  assign grp[1].wr_en = reg_wr && hit(reg_addr, OFS_GROUP1);
  assign grp[2].wr_en = reg_wr && hit(reg_addr, OFS_GROUP2);
  assign grp[0].wr_data = reg_wdata;
  assign grp[1].wr_data = reg_wdata;
  assign grp[2].wr_data = reg_wdata;
  assign flags0 = grp[0].flags;
  assign flags1 = grp[1].flags;
  assign flags2 = grp[2].flags;

  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g++) begin : g_bank
      irl_flag_bank u_bank (
        .clk(clk),
        .rstn(rstn),
        .fb(grp[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      edge_port_select <= RESET_EDGE_SEL;
    end else if (reg_wr && hit(reg_addr, OFS_EDGE_SEL)) begin
      edge_port_select <= reg_wdata; // R07
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      global_interrupt_enable <= 1'b0;
    end else if (reg_wr && hit(reg_addr, OFS_GLOBAL_EN)) begin
      global_interrupt_enable <= reg_wdata[GLOBAL_EN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Core outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_irq <= 1'b0;
    end else begin
      core_irq <= global_interrupt_enable && ((|flags0) || (|flags1) || (|flags2)); // R02 R03
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pending_group0 <= RESET_FLAGS;
    end else begin
      pending_group0 <= flags0; // R03
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pending_group1 <= RESET_FLAGS;
    end else begin
      pending_group1 <= flags1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pending_group2 <= RESET_FLAGS;
    end else begin
      pending_group2 <= flags2;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (hit(reg_addr, OFS_GROUP0)) begin
        reg_rdata <= flags0; // R05
      end else if (hit(reg_addr, OFS_GROUP1)) begin
        reg_rdata <= flags1;
      end else if (hit(reg_addr, OFS_GROUP2)) begin
        reg_rdata <= flags2;
      end else if (hit(reg_addr, OFS_EDGE_SEL)) begin
        reg_rdata <= edge_port_select;
      end else if (hit(reg_addr, OFS_GLOBAL_EN)) begin
        reg_rdata <= {global_interrupt_enable, 7'h00};
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : irl_request_latches
`default_nettype wire
